// ===== jtr_defines.svh
// Offsets, codes, field positions and reset values of the test data registers
`ifndef JTR_DEFINES_SVH
`define JTR_DEFINES_SVH
`define JTR_IR_W         4
`define JTR_OP_EXTEST    4'h0
`define JTR_OP_IDCODE    4'h1
`define JTR_OP_SAMPLE    4'h2
`define JTR_OP_PRIV_A    4'h8
`define JTR_OP_PRIV_B    4'h9
`define JTR_OP_PRIV_C    4'hA
`define JTR_OP_PRIV_D    4'hB
`define JTR_OP_TRESET    4'hC
`define JTR_OP_BYPASS    4'hF
`define JTR_IR_CAPTURE   4'h1
`define JTR_ID_W         32
`define JTR_VER_W        4
`define JTR_PART_W       16
`define JTR_MFR_W        11
`define JTR_ADDR_W       6
`define JTR_DBC_ADDR     6'h31
`define JTR_CCR_ADDR     6'h35
`define JTR_CCR_DIS_BIT  7
`define JTR_CCR_WIN      3'h4
`define JTR_DIRTY_BIT    7
`endif

// ===== jtr_pkg.sv
// Types shared by the test data register block
package jtr_pkg;
  // TAP controller state levels, one bit per state of interest
  typedef struct packed {
    logic tlr;
    logic cdr;
    logic sdr;
    logic udr;
    logic cir;
    logic sir;
    logic uir;
  } jtr_tap_t;
  // CPU I/O access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } jtr_cpu_t;
  // Core reset sequencing, one-hot
  typedef enum logic [2:0] {
    JTR_RUN  = 3'b001,
    JTR_HOLD = 3'b010,
    JTR_TOUT = 3'b100
  } jtr_rst_st_t;
endpackage

// ===== jtr_test_regs.sv
// Test data registers, port enable, debug fuse guard and debug byte channel
// Functional notes
// (R1) Codes 0x8-0xB reserved for private debug access
// (R2) Port live only with fuse set, disable clear
// (R3) Locked part refuses debug fuse until erase
// (R4) CPU write stores byte, sets dirty flag
// (R5) CPU read: low seven bits plus dirty MSB
// (R6) Debugger clears dirty flag after reading byte
// (R7) Shared address reaches channel only when enabled
// (R8) Identification is the default instruction
// (R9) EXTEST drives output latches onto pins immediately
// (R10) Controller should preload safe values before EXTEST
// (R11) SAMPLE captures pins without disturbing operation
// (R12) Reset floats every port pin output at once; EXTEST latches still drive the pins during reset
// (R13) Reset from pin low or reset instruction
// (R14) Scan works with fast test clock; the code samples tck on sys_clk, so each tck level must span a sys_clk edge
// (R15) Bypass is one stage, captures zero
// (R16) ID holds version, part and maker fields
// (R17) Reset register one holds device in reset
// (R18) Time-out after release chosen by clock fuses
// (R19) Reset register output is not latched
// (R20) Chain drives and observes pins and analog boundary
// (R21) Four-bit instruction, all shifting LSB first
// (R22) Code 0xC selects one-bit reset register
// (R23) Bypass 0xF, sample/preload 0x2 select their paths
// (R24) Private codes select one-bit path
`include "jtr_defines.svh"
module jtr_test_regs #(
  parameter int NPINS     = 8,
  parameter int ANA_W     = 2,
  parameter int TOUT_A    = 64,
  parameter int TOUT_B    = 1024,
  parameter logic [3:0]  VERSION = 4'h0,
  parameter logic [15:0] PART_NO = 16'h1234,  // arbitrary value
  parameter logic [10:0] MFR_ID  = 11'h055    // arbitrary value
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Test access port, from the external TAP controller
  input  wire logic                  tck,
  input  wire logic                  tdi,
  input  wire jtr_pkg::jtr_tap_t     tap_st,
  output logic                       tdo_o,
  output logic                       tdo_oe,
  // Fuses and lock bits
  input  wire logic                  test_port_enable_fuse,
  input  wire logic                  debug_enable_fuse,
  input  wire logic                  lock_bit_one,
  input  wire logic                  lock_bit_two,
  input  wire logic [0:0]            clk_opt_fuse,
  input  wire logic                  chip_erase_done,
  input  wire logic                  dbg_fuse_prog_req,
  output logic                       dbg_fuse_prog_ok,
  output logic                       dbg_fuse_refused,
  // CPU I/O port
  input  wire jtr_pkg::jtr_cpu_t     cpu_req,
  input  wire logic [7:0]            std_io_rdata,
  output logic [7:0]                 cpu_rdata,
  output logic                       std_io_wr,
  output logic                       std_io_rd,
  // Debugger side of the byte channel
  input  wire logic                  dbg_access_en,
  input  wire logic                  dbg_dirty_clr_tgl,
  output logic [7:0]                 debug_byte_channel,
  output logic                       debug_dirty_flag,
  // Pins, analog boundary and core reset
  input  wire logic                  ext_rst_n,
  input  wire logic [NPINS-1:0]      pin_in,
  input  wire logic [NPINS-1:0]      sys_out,
  input  wire logic [NPINS-1:0]      sys_oe,
  input  wire logic [ANA_W-1:0]      ana_in,
  input  wire logic [ANA_W-1:0]      sys_ana_ctl,
  output logic [NPINS-1:0]           pad_out,
  output logic [NPINS-1:0]           pad_oe,
  output logic [ANA_W-1:0]           ana_ctl,
  output logic                       core_rst
);
  import jtr_pkg::*;

  localparam int BS_W = 2 * NPINS + 2 * ANA_W;
  localparam int SW   = 12 + NPINS + ANA_W;

  // Synchroniser: tck, tdi, tap states, access enable, clear toggle, reset pin, pins
  logic [SW-1:0] s1_ff;
  logic [SW-1:0] s2_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= {ana_in, pin_in, ext_rst_n, dbg_dirty_clr_tgl, dbg_access_en, tap_st, tdi, tck};
      s2_ff <= s1_ff;
    end
  end

  logic             tck_s;
  logic             tdi_s;
  jtr_tap_t         st_s;
  logic             acc_en_s;
  logic             clr_s;
  logic             ext_rst_n_s;
  logic [NPINS-1:0] pin_s;
  logic [ANA_W-1:0] ana_s;
  assign {ana_s, pin_s, ext_rst_n_s, clr_s, acc_en_s, st_s, tdi_s, tck_s} = s2_ff;

  // Edge finders on the synchronised test clock and clear toggle
  logic tck_d_ff;
  logic clr_d_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tck_d_ff <= 1'b0;
      clr_d_ff <= 1'b0;
    end else begin
      tck_d_ff <= tck_s;
      clr_d_ff <= clr_s;
    end
  end
  wire tck_rise = tck_s & ~tck_d_ff;  // [R14]
  wire tck_fall = ~tck_s & tck_d_ff;

  // Timed write of the port-disable bit: same value twice within the window
  logic       test_port_disable_bit_ff;
  logic       pend_val_ff;
  logic [2:0] pend_cnt_ff;
  wire ccr_wr = cpu_req.wr & (cpu_req.addr == `JTR_CCR_ADDR);
  wire new_dis = cpu_req.wdata[`JTR_CCR_DIS_BIT];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      test_port_disable_bit_ff <= 1'b0;
      pend_val_ff              <= 1'b0;
      pend_cnt_ff              <= 3'h0;
    end else if (ccr_wr && pend_cnt_ff != 3'h0 && new_dis == pend_val_ff) begin
      test_port_disable_bit_ff <= new_dis;
      pend_cnt_ff              <= 3'h0;
    end else if (ccr_wr) begin
      pend_val_ff <= new_dis;
      pend_cnt_ff <= `JTR_CCR_WIN;
    end else if (pend_cnt_ff != 3'h0) begin
      pend_cnt_ff <= pend_cnt_ff - 3'h1;
    end
  end
  wire port_en = test_port_enable_fuse & ~test_port_disable_bit_ff;  // [R2]

  // Instruction decode, used for path select and pin control
  function automatic logic is_priv(input logic [3:0] op);
    is_priv = (op >= `JTR_OP_PRIV_A) && (op <= `JTR_OP_PRIV_D);  // [R1]
  endfunction
  function automatic logic is_bs(input logic [3:0] op);
    is_bs = (op == `JTR_OP_EXTEST) || (op == `JTR_OP_SAMPLE);  // [R23]
  endfunction

  // Instruction register, 4 bits, LSB first
  logic [`JTR_IR_W-1:0] ir_ff;
  logic [`JTR_IR_W-1:0] ir_sh_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ir_ff    <= `JTR_OP_IDCODE;
      ir_sh_ff <= `JTR_IR_CAPTURE;
    end else if (!port_en || (tck_rise && st_s.tlr)) begin
      ir_ff    <= `JTR_OP_IDCODE;  // [R8]
      ir_sh_ff <= `JTR_IR_CAPTURE;
    end else if (tck_rise) begin
      if (st_s.cir)
        ir_sh_ff <= `JTR_IR_CAPTURE;
      if (st_s.sir)
        ir_sh_ff <= {tdi_s, ir_sh_ff[`JTR_IR_W-1:1]};  // [R21]
      if (st_s.uir)
        ir_ff <= ir_sh_ff;
    end
  end

  wire sel_id   = (ir_ff == `JTR_OP_IDCODE);
  wire sel_rst  = (ir_ff == `JTR_OP_TRESET);  // [R22]
  wire sel_bs   = is_bs(ir_ff);
  wire sel_byp  = ~sel_id & ~sel_rst & ~sel_bs;  // [R24]
  wire extest   = port_en & (ir_ff == `JTR_OP_EXTEST);

  // Bypass, identification and reset data registers
  logic                 byp_ff;
  logic [`JTR_ID_W-1:0] id_sh_ff;
  logic                 rstreg_ff;
  wire [`JTR_ID_W-1:0]  id_word = {VERSION, PART_NO, MFR_ID, 1'b1};  // [R16]
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      byp_ff    <= 1'b0;
      id_sh_ff  <= '0;
      rstreg_ff <= 1'b0;
    end else if (!port_en || (tck_rise && st_s.tlr)) begin
      byp_ff    <= 1'b0;
      rstreg_ff <= 1'b0;
    end else if (tck_rise) begin
      if (st_s.cdr && sel_byp)
        byp_ff <= 1'b0;  // [R15]
      if (st_s.sdr && sel_byp)
        byp_ff <= tdi_s;
      if (st_s.cdr && sel_id)
        id_sh_ff <= id_word;
      if (st_s.sdr && sel_id)
        id_sh_ff <= {tdi_s, id_sh_ff[`JTR_ID_W-1:1]};  // [R21]
      if (st_s.sdr && sel_rst)
        rstreg_ff <= tdi_s;  // [R22]
    end
  end

  // Boundary chain: pin data, pin control, analog in, analog control
  logic [BS_W-1:0] bs_sh_ff;
  logic [BS_W-1:0] bs_lat_ff;
  wire  [BS_W-1:0] bs_cap = {sys_ana_ctl, ana_s, sys_oe, pin_s};  // [R20]
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bs_sh_ff  <= '0;
      bs_lat_ff <= '0;
    end else if (tck_rise && port_en && sel_bs) begin
      if (st_s.cdr)
        bs_sh_ff <= bs_cap;  // [R11]
      if (st_s.sdr)
        bs_sh_ff <= {tdi_s, bs_sh_ff[BS_W-1:1]};
      if (st_s.udr)
        bs_lat_ff <= bs_sh_ff;
    end
  end

  // Test data out changes on the falling test clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tdo_o  <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (!port_en) begin
      tdo_o  <= 1'b0;
      tdo_oe <= 1'b0;  // [R2]
    end else if (tck_fall) begin
      tdo_oe <= st_s.sdr | st_s.sir;
      if (st_s.sir || st_s.cir)  // Capture value must lead the instruction shift
        tdo_o <= ir_sh_ff[0];
      else if (sel_id)
        tdo_o <= id_sh_ff[0];
      else if (sel_rst)
        tdo_o <= rstreg_ff;
      else if (sel_bs)
        tdo_o <= bs_sh_ff[0];
      else
        tdo_o <= byp_ff;
    end
  end

  // Core reset sequencing; the reset register feeds this directly, no update latch
  jtr_rst_st_t rst_st_ff;
  logic [15:0] tout_ff;
  wire hold_req = ~ext_rst_n_s | (port_en & sel_rst & rstreg_ff);  // [R13] [R17] [R19]
  wire [15:0] tout_len = clk_opt_fuse[0] ? 16'(TOUT_B) : 16'(TOUT_A);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_st_ff <= JTR_HOLD;
      tout_ff   <= 16'h0000;
    end else begin
      case (rst_st_ff)
        JTR_RUN: if (hold_req) begin
          rst_st_ff <= JTR_HOLD;
        end
        JTR_HOLD: if (!hold_req) begin
          rst_st_ff <= JTR_TOUT;
          tout_ff   <= tout_len;  // [R18]
        end
        JTR_TOUT: begin
          if (hold_req)
            rst_st_ff <= JTR_HOLD;
          else if (tout_ff <= 16'h0001)
            rst_st_ff <= JTR_RUN;
          tout_ff <= tout_ff - 16'h0001;
        end
        default: rst_st_ff <= JTR_HOLD;
      endcase
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      core_rst <= 1'b1;
    else
      core_rst <= hold_req | (rst_st_ff != JTR_RUN);
  end

  // Pin drive: EXTEST latches first, then reset float, then system logic
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pad_out <= '0;
      pad_oe  <= '0;
      ana_ctl <= '0;
    end else if (extest) begin
      pad_out <= bs_lat_ff[NPINS-1:0];  // [R9]
      pad_oe  <= bs_lat_ff[2*NPINS-1:NPINS];
      ana_ctl <= bs_lat_ff[BS_W-1:BS_W-ANA_W];  // [R20]
    end else if (hold_req || core_rst) begin
      pad_out <= '0;
      pad_oe  <= '0;  // [R12]
      ana_ctl <= '0;
    end else begin
      pad_out <= sys_out;
      pad_oe  <= sys_oe;
      ana_ctl <= sys_ana_ctl;
    end
  end

  // Debug fuse guard: lock bits block programming until an erase is seen
  logic erased_ff;
  wire  locked = (lock_bit_one | lock_bit_two) & ~erased_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      erased_ff        <= 1'b0;
      dbg_fuse_prog_ok <= 1'b0;
      dbg_fuse_refused <= 1'b0;
    end else begin
      if (chip_erase_done)
        erased_ff <= 1'b1;
      dbg_fuse_prog_ok <= dbg_fuse_prog_req & ~locked;  // [R3]
      dbg_fuse_refused <= dbg_fuse_prog_req & locked;
    end
  end

  // Byte channel; a write in the clear cycle keeps the flag set
  wire dbc_hit = (cpu_req.addr == `JTR_DBC_ADDR);
  wire dbc_sel = dbc_hit & debug_enable_fuse & acc_en_s;  // [R7]
  wire clr_evt = clr_s ^ clr_d_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      debug_byte_channel <= 8'h00;
      debug_dirty_flag   <= 1'b0;
    end else begin
      if (cpu_req.wr && dbc_sel) begin
        debug_byte_channel <= cpu_req.wdata;  // [R4]
        debug_dirty_flag   <= 1'b1;
      end else if (clr_evt) begin
        debug_dirty_flag <= 1'b0;  // [R6]
      end
    end
  end

  // CPU read data and forwarding to the standard location
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cpu_rdata <= 8'h00;
      std_io_wr <= 1'b0;
      std_io_rd <= 1'b0;
    end else begin
      std_io_wr <= cpu_req.wr & dbc_hit & ~dbc_sel;  // [R7]
      std_io_rd <= cpu_req.rd & dbc_hit & ~dbc_sel;
      if (cpu_req.rd && dbc_sel)
        cpu_rdata <= {debug_dirty_flag, debug_byte_channel[6:0]};  // [R5]
      else if (cpu_req.rd && dbc_hit)
        cpu_rdata <= std_io_rdata;
      else if (cpu_req.rd && cpu_req.addr == `JTR_CCR_ADDR)
        cpu_rdata <= {test_port_disable_bit_ff, 7'h00};
      else
        cpu_rdata <= 8'h00;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_bypass_zero: assert property (tck_rise && st_s.cdr && sel_byp && port_en |=> !byp_ff) // [R15]
    else $error("bypass did not capture zero");
  a_id_default: assert property ((!port_en || (tck_rise && st_s.tlr)) |=> ir_ff == `JTR_OP_IDCODE) // [R8]
    else $error("identification not default after test reset");
  a_port_gate: assert property (!port_en |=> !tdo_oe) // [R2]
    else $error("tdo driven while port disabled");
  a_dirty_set: assert property (cpu_req.wr && dbc_sel |=>  // [R4]
    debug_dirty_flag && debug_byte_channel == $past(cpu_req.wdata))
    else $error("channel write did not set dirty");
  a_read_format: assert property (cpu_req.rd && dbc_sel |=>  // [R5]
    cpu_rdata == {$past(debug_dirty_flag), $past(debug_byte_channel[6:0])})
    else $error("dirty flag not in read MSB");
  a_fuse_lock: assert property (dbg_fuse_prog_req && locked |=> !dbg_fuse_prog_ok && dbg_fuse_refused) // [R3]
    else $error("debug fuse programmed while locked");
  a_reset_hold: assert property (port_en && sel_rst && rstreg_ff |=> core_rst) // [R17]
    else $error("reset register one did not reset core");
  a_float_reset: assert property (core_rst && !extest |=> pad_oe == '0) // [R12]
    else $error("pins driven during reset");
  a_extest_drive: assert property (extest |=> pad_out == $past(bs_lat_ff[NPINS-1:0])) // [R9]
    else $error("extest latches not on pins");
  a_tout_hold: assert property (rst_st_ff == JTR_HOLD && !hold_req |=> core_rst [*2]) // [R18]
    else $error("core left reset without time-out");

  c_extest: cover property (extest ##1 pad_oe != '0);
  c_dirty_cycle: cover property (debug_dirty_flag ##[1:50] !debug_dirty_flag);
  c_jtag_reset: cover property (sel_rst && rstreg_ff ##[1:20] core_rst);
endmodule

// ===== jtr_tap_model.sv
// Behavioural external test controller and debugger facing the test data registers
module jtr_tap_model (
  // Scan link toward the block
  output logic              tck,
  output logic              tdi,
  output jtr_pkg::jtr_tap_t tap_st,
  input  wire logic         tdo_o,
  input  wire logic         tdo_oe,
  // Debugger controls of the byte channel
  output logic              dbg_access_en,
  output logic              dbg_dirty_clr_tgl
);
  timeunit 1ns;
  timeprecision 1ps;
  import jtr_pkg::*;
  localparam jtr_tap_t S_CDR = 7'h20;
  localparam jtr_tap_t S_SDR = 7'h10;
  localparam jtr_tap_t S_UDR = 7'h08;
  localparam jtr_tap_t S_CIR = 7'h04;
  localparam jtr_tap_t S_SIR = 7'h02;
  localparam jtr_tap_t S_UIR = 7'h01;
  localparam jtr_tap_t S_TLR = 7'h40;
  logic oe_seen;  // Set when tdo was driven in any tick
  // Idle link: clock parked low, no state asserted
  initial begin
    tck <= 1'b0;
    tdi <= 1'b0;
    tap_st <= '0;
    dbg_access_en <= 1'b0;
    dbg_dirty_clr_tgl <= 1'b0;
    oe_seen = 1'b0;
  end
  // One 320 ns test clock period; state and data lead the rise so one sampling edge sees all three
  task automatic tick(input jtr_tap_t st, input logic d, output logic o);
    tap_st <= st;
    tdi    <= d;
    #1;
    tck <= 1'b1;
    #158;
    o = tdo_o;
    if (tdo_oe === 1'b1) oe_seen = 1'b1;
    #1;
    tck <= 1'b0;
    #160;
  endtask
  // One tick in test-logic-reset, then idle
  task automatic tlr_reset();
    logic o;
    tick(S_TLR, 1'b0, o);
    tick('0, 1'b0, o);
  endtask
  // Data register scan, least significant bit first
  task automatic scan_dr(input int n, input logic [63:0] din, output logic [63:0] dout);
    logic o;
    dout = '0;
    tick(S_CDR, ~tdi, o);
    for (int i = 0; i < n; i++) begin
      tick(S_SDR, din[i], o);
      dout[i] = o;
    end
    tick(S_UDR, ~tdi, o);  // Released data line shows the inverse, not a stale bit
    tick('0, ~tdi, o);
  endtask
  // Instruction scan, four bits, least significant bit first
  task automatic scan_ir(input logic [3:0] op, output logic [3:0] cap);
    logic o;
    tick(S_CIR, ~tdi, o);
    for (int i = 0; i < 4; i++) begin
      tick(S_SIR, op[i], o);
      cap[i] = o;
    end
    tick(S_UIR, ~tdi, o);
    tick('0, ~tdi, o);
  endtask
  // Debugger has read the byte, so it clears the dirty flag
  task automatic clear_dirty();
    dbg_dirty_clr_tgl <= ~dbg_dirty_clr_tgl;
  endtask
  task automatic set_access(input logic v);
    dbg_access_en <= v;
  endtask
endmodule

// ===== jtr_test_regs_tb.sv
// Self-checking bench for the test data register block
`include "jtr_defines.svh"
module jtr_test_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import jtr_pkg::*;
  localparam logic [3:0]  VER  = 4'h3;     // arbitrary value
  localparam logic [15:0] PART = 16'h5a5a; // arbitrary value
  localparam logic [10:0] MFR  = 11'h2b3;  // arbitrary value
  logic       sys_clk, rst, tck, tdi, tdo_o, tdo_oe, fuse_en, dbg_fuse, lk1, lk2, erase;
  logic       freq, fok, fref, std_wr, std_rd, acc_en, clr_tgl, dirty, ext_rst_n, core_rst;
  logic [0:0] clk_opt;
  jtr_tap_t   tap_st;
  jtr_cpu_t   cpu_req;
  logic [7:0] std_rdata, cpu_rdata, dbc, pin_in, sys_out, sys_oe, pad_out, pad_oe;
  logic [1:0] ana_in, sys_ana, ana_ctl;
  int         num_errors, n_checks;
  // Short time-outs keep the run brief
  jtr_test_regs #(.NPINS(8), .ANA_W(2), .TOUT_A(100), .TOUT_B(200), .VERSION(VER), .PART_NO(PART),
    .MFR_ID(MFR)) dut (
    .sys_clk(sys_clk), .rst(rst), .tck(tck), .tdi(tdi), .tap_st(tap_st), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .test_port_enable_fuse(fuse_en), .debug_enable_fuse(dbg_fuse), .lock_bit_one(lk1), .lock_bit_two(lk2),
    .clk_opt_fuse(clk_opt), .chip_erase_done(erase), .dbg_fuse_prog_req(freq), .dbg_fuse_prog_ok(fok),
    .dbg_fuse_refused(fref), .cpu_req(cpu_req), .std_io_rdata(std_rdata), .cpu_rdata(cpu_rdata),
    .std_io_wr(std_wr), .std_io_rd(std_rd), .dbg_access_en(acc_en), .dbg_dirty_clr_tgl(clr_tgl),
    .debug_byte_channel(dbc), .debug_dirty_flag(dirty), .ext_rst_n(ext_rst_n), .pin_in(pin_in),
    .sys_out(sys_out), .sys_oe(sys_oe), .ana_in(ana_in), .sys_ana_ctl(sys_ana), .pad_out(pad_out),
    .pad_oe(pad_oe), .ana_ctl(ana_ctl), .core_rst(core_rst));
  jtr_tap_model tap (.tck(tck), .tdi(tdi), .tap_st(tap_st), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .dbg_access_en(acc_en), .dbg_dirty_clr_tgl(clr_tgl));
  // System clock, 25 MHz
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    n_checks++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // Bounded wait for the core reset to end; exhaustion ends the run
  task automatic wait_low(output int n);
    n = 0;
    while (core_rst !== 1'b0 && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      $display("wrong value core_rst expected 0 seen 1");
      conclude();
    end
  endtask
  // One CPU access; results sampled after the taking edge
  task automatic cpu(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_req <= {w, ~w, a, d};
    @(posedge sys_clk);
    cpu_req <= '0;
    #1;
  endtask
  task automatic t_idcode();
    logic [63:0] d;
    tap.scan_dr(32, 64'h0, d);
    chk("idcode", {VER, PART, MFR, 1'b1}, d[31:0]);
    chk("tdo_oe_on", 32'h1, 32'(tap.oe_seen));
  endtask
  // Bypass and private codes each give a one-stage path that captures zero
  task automatic t_bypass();
    logic [3:0] ops [5];
    logic [3:0] c;
    logic [63:0] d;
    ops = '{`JTR_OP_BYPASS, `JTR_OP_PRIV_A, `JTR_OP_PRIV_B, `JTR_OP_PRIV_C, `JTR_OP_PRIV_D};
    foreach (ops[i]) begin
      tap.scan_ir(ops[i], c);
      chk("ir_capture", 32'(`JTR_IR_CAPTURE), 32'(c));
      tap.scan_dr(3, 64'h6, d);
      chk("one_bit_path", 32'h4, 32'(d[2:0]));
    end
    tap.tlr_reset();
    tap.scan_dr(32, 64'h0, d);
    chk("idcode_tlr", {VER, PART, MFR, 1'b1}, d[31:0]);
  endtask
  // Safe values preloaded before the first EXTEST
  task automatic t_sample_extest();
    logic [3:0] c;
    logic [63:0] d;
    @(posedge sys_clk);
    pin_in <= 8'h96;
    ana_in <= 2'h2;
    tap.scan_ir(`JTR_OP_SAMPLE, c);
    tap.scan_dr(20, 64'h0000_0000_0004_0f5a, d);
    chk("snap_pins", 32'h96, 32'(d[7:0]));
    chk("snap_ana", 32'h2, 32'(d[17:16]));
    chk("normal_out", 32'h3c, 32'(pad_out));
    chk("normal_oe", 32'hf0, 32'(pad_oe));
    tap.scan_ir(`JTR_OP_EXTEST, c);
    chk("ext_out", 32'h5a, 32'(pad_out));
    chk("ext_oe", 32'h0f, 32'(pad_oe));
    chk("ext_ana", 32'h1, 32'(ana_ctl));
  endtask
  task automatic t_reset_op();
    logic [3:0] c;
    logic [63:0] d;
    int n;
    tap.scan_ir(`JTR_OP_TRESET, c);
    for (int f = 0; f < 2; f++) begin
      @(posedge sys_clk);
      clk_opt <= 1'(f);
      tap.scan_dr(1, 64'h1, d);
      repeat (50) @(posedge sys_clk);
      #1;
      chk("rst_held", 32'h1, 32'(core_rst));
      chk("pads_float", 32'h0, 32'(pad_oe));
      tap.scan_dr(1, 64'h0, d);
      wait_low(n);
      chk_rng("tout_left", f ? 165 : 65, f ? 200 : 100, n);
    end
    @(posedge sys_clk);
    ext_rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    chk("pin_rst", 32'h1, 32'(core_rst));
    chk("pin_float", 32'h0, 32'(pad_oe));
    @(posedge sys_clk);
    ext_rst_n <= 1'b1;
    wait_low(n);
    chk_rng("pin_tout", 195, 215, n);
  endtask
  task automatic t_channel();
    int n;
    @(posedge sys_clk);
    dbg_fuse <= 1'b1;
    tap.set_access(1'b1);
    repeat (6) @(posedge sys_clk);
    cpu(1'b1, `JTR_DBC_ADDR, 8'h25);
    chk("chan_byte", 32'h25, 32'(dbc));
    chk("dirty_set", 32'h1, 32'(dirty));
    chk("no_std_wr", 32'h0, 32'(std_wr));
    cpu(1'b0, `JTR_DBC_ADDR, 8'h00);
    chk("chan_rd", 32'ha5, 32'(cpu_rdata));
    tap.clear_dirty();
    for (n = 0; n < 20 && dirty !== 1'b0; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("dirty_clr", 32'h0, 32'(dirty));
    if (dirty !== 1'b0) conclude();
    cpu(1'b0, `JTR_DBC_ADDR, 8'h00);
    chk("chan_rd_clean", 32'h25, 32'(cpu_rdata));
    tap.set_access(1'b0);
    repeat (6) @(posedge sys_clk);
    std_rdata <= 8'h91;
    cpu(1'b1, `JTR_DBC_ADDR, 8'h3c);
    chk("std_wr", 32'h1, 32'(std_wr));
    chk("chan_kept", 32'h25, 32'(dbc));
    cpu(1'b0, `JTR_DBC_ADDR, 8'h00);
    chk("std_rd", 32'h1, 32'(std_rd));
    chk("std_data", 32'h91, 32'(cpu_rdata));
    cpu(1'b0, 6'h10, 8'h00);
    chk("unmapped", 32'h0, 32'(cpu_rdata));
  endtask
  task automatic fuse(output logic ok, output logic rf);
    @(posedge sys_clk);
    freq <= 1'b1;
    @(posedge sys_clk);
    freq <= 1'b0;
    #1;
    ok = fok;
    rf = fref;
    @(posedge sys_clk);
    #1;
    ok = ok | fok;
    rf = rf | fref;
  endtask
  task automatic t_fuse();
    logic ok, rf;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      lk1 <= (i == 0);
      lk2 <= (i != 0);
      erase <= (i == 2);
      @(posedge sys_clk);
      erase <= 1'b0;
      fuse(ok, rf);
      chk("fuse_ok", 32'(i == 2), 32'(ok));
      chk("fuse_refused", 32'(i != 2), 32'(rf));
    end
  endtask
  // A lone write must not flip the disable bit; a close pair must
  task automatic t_disable();
    logic [63:0] d;
    cpu(1'b1, `JTR_CCR_ADDR, 8'h80);
    repeat (8) @(posedge sys_clk);
    cpu(1'b0, `JTR_CCR_ADDR, 8'h00);
    chk("ccr_single", 32'h0, 32'(cpu_rdata));
    repeat (8) @(posedge sys_clk);
    cpu(1'b1, `JTR_CCR_ADDR, 8'h80);
    cpu(1'b1, `JTR_CCR_ADDR, 8'h80);
    cpu(1'b0, `JTR_CCR_ADDR, 8'h00);
    chk("ccr_pair", 32'h80, 32'(cpu_rdata));
    tap.oe_seen = 1'b0;
    tap.scan_dr(32, 64'h0, d);
    chk("tdo_oe_off", 32'h0, 32'(tap.oe_seen));
    cpu(1'b1, `JTR_CCR_ADDR, 8'h00);
    cpu(1'b1, `JTR_CCR_ADDR, 8'h00);
    // Unprogrammed enable fuse keeps the port silent as well
    @(posedge sys_clk);
    fuse_en <= 1'b0;
    tap.oe_seen = 1'b0;
    tap.scan_dr(32, 64'h0, d);
    chk("fuse_off", 32'h0, 32'(tap.oe_seen));
    @(posedge sys_clk);
    fuse_en <= 1'b1;
    tap.oe_seen = 1'b0;
    tap.scan_dr(32, 64'h0, d);
    chk("idcode_again", {VER, PART, MFR, 1'b1}, d[31:0]);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    fuse_en = 1'b1;
    dbg_fuse = 1'b0;
    lk1 = 1'b0;
    lk2 = 1'b0;
    erase = 1'b0;
    freq = 1'b0;
    clk_opt = 1'b0;
    cpu_req = '0;
    std_rdata = 8'h6e;
    ext_rst_n = 1'b1;
    pin_in = 8'h00;
    sys_out = 8'h3c;
    sys_oe = 8'hf0;
    ana_in = 2'h0;
    sys_ana = 2'h3;
    num_errors = 0;
    n_checks = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_idcode();
    t_bypass();
    t_sample_extest();
    t_reset_op();
    t_channel();
    t_fuse();
    t_disable();
    conclude();
  end
endmodule
